/* logic/csh_slots.sv */
// Four-slot command handshake engine with host register port and memory port.
// Assumes register port, memory port and executor share clock; scan_end is a pin.
// Summary of operation
// - Idle slot with request raises busy, latches mode, fetches block, starts.
// - Coupled finish: request low drops busy, else busy held until low.
// - Uncoupled: busy low and request high starts; finish drops busy unconditionally.
// - Uncoupled held request repeats at each following scan end.
// - Execution error writes code to error word, sets execution fault, halts.
// - Failed error word write also sets memory fetch fault.
// - Unreadable block sets both faults, halts, writes nothing.
// - Faulted slot samples acknowledge at scan end, clears faults, recovers, drops busy.
// - Execution fault only with busy; faults clear no later than busy.
// - Acknowledge is a level sampled only while faulted.
// - Cancel during command raises cancel busy, clears it, then clears busy.
// - Cancel busy never without busy in the same slot.
// - Cancel busy clears despite held cancel; held cancel blocks new commands.
// - All four cancels plus module reset bit reset all slots and the memory port; slot control word and pointers keep their values.
// - Slots run independently except for full reset and shared memory port.
// - Connection high byte without signature marks block invalid, both faults.
// - Each slot owns one nibble of status and control words.
// - Pointer holds block address; zero is invalid; 16 bits reach 64k.
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "csh_regs.svh"

module csh_slots (
  input wire logic clock,
  input wire logic rst,
  input wire csh_pkg::csh_addr_t reg_addr,
  input wire csh_pkg::csh_word_t reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output csh_pkg::csh_word_t reg_rdata,
  input wire logic scan_end,
  output logic mem_req,
  output logic mem_we,
  output csh_pkg::csh_word_t mem_addr,
  output csh_pkg::csh_word_t mem_wdata,
  input wire logic mem_ack,
  input wire logic mem_fail,
  input wire csh_pkg::csh_word_t mem_rdata,
  output logic [3:0] exec_start,
  output logic [3:0] exec_abort,
  input wire logic [3:0] exec_done,
  input wire logic [3:0] exec_err,
  input wire logic [63:0] exec_code
);
  import csh_pkg::*;

  // One bit of a slot nibble, used only on the control word; status is built by index
  function automatic logic nib(input csh_word_t w, input int slot, input int pos);
    nib = w[`CSH_NIB * slot + pos];
  endfunction

  csh_word_t ctl_q, modctl_q, rdata_q;
  csh_word_t ptr_q [`CSH_SLOTS];
  csh_word_t code_q [`CSH_SLOTS];
  csh_state_e st_q [`CSH_SLOTS];
  logic [3:0] busy_q, xf_q, mf_q, cb_q, coupled_q, start_q, abort_q;
  logic scan_meta_q, scan_sync_q, scan_prev_q, scan_tick;
  logic mem_busy_q, mem_we_q;
  csh_slot_t mem_slot_q;
  csh_word_t mem_addr_q, mem_wdata_q;
  logic [3:0] mem_done, want;
  logic soft_rst;
  csh_word_t status_w;

  // Scan end is a host pin: two flops, then edge detect on the clean copy
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scan_meta_q <= 1'b0;
      scan_sync_q <= 1'b0;
      scan_prev_q <= 1'b0;
    end else begin
      scan_meta_q <= scan_end;
      scan_sync_q <= scan_meta_q;
      scan_prev_q <= scan_sync_q;
    end
  end
  assign scan_tick = scan_sync_q & ~scan_prev_q;

  // Full reset needs all four cancels and the reset bit together
  assign soft_rst = modctl_q[`CSH_MOD_RST] & nib(ctl_q, 0, `CSH_CT_CANCEL)
    & nib(ctl_q, 1, `CSH_CT_CANCEL) & nib(ctl_q, 2, `CSH_CT_CANCEL)
    & nib(ctl_q, 3, `CSH_CT_CANCEL);

  // Host-written words; the reset bit drops itself once acted upon
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctl_q <= `CSH_WORD_RST;
      modctl_q <= `CSH_WORD_RST;
      for (int i = 0; i < `CSH_SLOTS; i++) begin
        ptr_q[i] <= `CSH_WORD_RST;
      end
    end else begin
      if (soft_rst) begin
        modctl_q[`CSH_MOD_RST] <= 1'b0;
      end
      if (reg_write) begin
        case (reg_addr)
          `CSH_ADDR_CONTROL: ctl_q <= reg_wdata;
          `CSH_ADDR_MODCTL: modctl_q <= reg_wdata;
          default: begin
            for (int i = 0; i < `CSH_SLOTS; i++) begin
              if (reg_addr == `CSH_ADDR_PTR0 + csh_addr_t'(i)) begin
                ptr_q[i] <= reg_wdata;
              end
            end
          end
        endcase
      end
    end
  end

  // Status nibbles assembled from the slot flags
  always_comb begin
    status_w = `CSH_WORD_RST;
    for (int i = 0; i < `CSH_SLOTS; i++) begin
      status_w[`CSH_NIB * i + `CSH_ST_XFAULT] = xf_q[i];
      status_w[`CSH_NIB * i + `CSH_ST_MFAULT] = mf_q[i];
      status_w[`CSH_NIB * i + `CSH_ST_BUSY] = busy_q[i];
      status_w[`CSH_NIB * i + `CSH_ST_CBUSY] = cb_q[i];
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_q <= `CSH_WORD_RST;
    end else if (reg_read) begin
      case (reg_addr)
        `CSH_ADDR_STATUS: rdata_q <= status_w;
        `CSH_ADDR_CONTROL: rdata_q <= ctl_q;
        `CSH_ADDR_MODCTL: rdata_q <= modctl_q;
        default: begin
          rdata_q <= `CSH_WORD_RST;
          for (int i = 0; i < `CSH_SLOTS; i++) begin
            if (reg_addr == `CSH_ADDR_PTR0 + csh_addr_t'(i)) begin
              rdata_q <= ptr_q[i];
            end
          end
        end
      endcase
    end else begin
      rdata_q <= `CSH_WORD_RST;
    end
  end

  // Slots wanting the shared memory port, and completion per slot
  always_comb begin
    for (int i = 0; i < `CSH_SLOTS; i++) begin
      want[i] = (st_q[i] == ST_FETCH) || (st_q[i] == ST_ERRWR);
      mem_done[i] = mem_busy_q && mem_ack && (mem_slot_q == csh_slot_t'(i));
    end
  end

  // Memory port: fixed priority, lowest slot first; one access at a time
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_busy_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_slot_q <= 2'h0;
      mem_addr_q <= `CSH_WORD_RST;
      mem_wdata_q <= `CSH_WORD_RST;
    end else if (soft_rst) begin
      mem_busy_q <= 1'b0;
      mem_we_q <= 1'b0;
    end else if (mem_busy_q) begin
      if (mem_ack) begin
        mem_busy_q <= 1'b0;
        mem_we_q <= 1'b0;
      end
    end else begin
      for (int i = `CSH_SLOTS - 1; i >= 0; i--) begin
        if (want[i]) begin
          mem_busy_q <= 1'b1;
          mem_slot_q <= csh_slot_t'(i);
          mem_we_q <= (st_q[i] == ST_ERRWR);
          mem_addr_q <= ptr_q[i] + ((st_q[i] == ST_ERRWR) ? `CSH_OFS_ERRWORD : `CSH_OFS_CONN);
          mem_wdata_q <= code_q[i];
        end
      end
    end
  end

  // Per-slot handshake machines; each slot touches only its own state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `CSH_SLOTS; i++) begin
        st_q[i] <= ST_IDLE;
        code_q[i] <= `CSH_WORD_RST;
      end
      busy_q <= 4'h0;
      xf_q <= 4'h0;
      mf_q <= 4'h0;
      cb_q <= 4'h0;
      coupled_q <= 4'h0;
      start_q <= 4'h0;
      abort_q <= 4'h0;
    end else if (soft_rst) begin
      for (int i = 0; i < `CSH_SLOTS; i++) begin
        st_q[i] <= ST_IDLE;
      end
      busy_q <= 4'h0;
      xf_q <= 4'h0;
      mf_q <= 4'h0;
      cb_q <= 4'h0;
      start_q <= 4'h0;
      abort_q <= 4'h0;
    end else begin
      start_q <= 4'h0;
      for (int i = 0; i < `CSH_SLOTS; i++) begin
        case (st_q[i])
          ST_IDLE: begin
            // Held cancel locks the slot; restart only at a scan end
            if (scan_tick && nib(ctl_q, i, `CSH_CT_REQ)
                && !nib(ctl_q, i, `CSH_CT_CANCEL)) begin
              busy_q[i] <= 1'b1;
              coupled_q[i] <= nib(ctl_q, i, `CSH_CT_SYNC);
              if (ptr_q[i] == `CSH_NULL_PTR) begin
                // Null pointer cannot name a block: fault without any access
                xf_q[i] <= 1'b1;
                mf_q[i] <= 1'b1;
                st_q[i] <= ST_FAULT;
              end else begin
                st_q[i] <= ST_FETCH;
              end
            end
          end
          ST_FETCH: begin
            if (mem_done[i]) begin
              if (mem_fail || mem_rdata[15:8] != `CSH_SIG) begin
                xf_q[i] <= 1'b1;
                mf_q[i] <= 1'b1;
                st_q[i] <= ST_FAULT;
              end else begin
                start_q[i] <= 1'b1;
                st_q[i] <= ST_RUN;
              end
            end
          end
          ST_RUN: begin
            if (nib(ctl_q, i, `CSH_CT_CANCEL)) begin
              cb_q[i] <= 1'b1;
              abort_q[i] <= 1'b1;
              st_q[i] <= ST_ABORT;
            end else if (exec_done[i] && exec_err[i]) begin
              code_q[i] <= exec_code[16 * i +: 16];
              st_q[i] <= ST_ERRWR;
            end else if (exec_done[i]) begin
              if (coupled_q[i] && nib(ctl_q, i, `CSH_CT_REQ)) begin
                st_q[i] <= ST_HOLD;
              end else begin
                busy_q[i] <= 1'b0;
                st_q[i] <= ST_IDLE;
              end
            end
          end
          ST_ERRWR: begin
            if (mem_done[i]) begin
              xf_q[i] <= 1'b1;
              mf_q[i] <= mem_fail;
              st_q[i] <= ST_FAULT;
            end
          end
          ST_FAULT: begin
            // Level sample at scan end only; a held acknowledge clears at the next scan end
            if (scan_tick && nib(ctl_q, i, `CSH_CT_ACK)) begin
              xf_q[i] <= 1'b0;
              mf_q[i] <= 1'b0;
              st_q[i] <= ST_RECOV;
            end
          end
          ST_RECOV: begin
            busy_q[i] <= 1'b0;
            st_q[i] <= ST_IDLE;
          end
          ST_HOLD: begin
            if (!nib(ctl_q, i, `CSH_CT_REQ)) begin
              busy_q[i] <= 1'b0;
              st_q[i] <= ST_IDLE;
            end
          end
          ST_ABORT: begin
            // Cancel busy drops on executor reply even if cancel stays high
            if (exec_done[i]) begin
              cb_q[i] <= 1'b0;
              abort_q[i] <= 1'b0;
              st_q[i] <= ST_ABEND;
            end
          end
          ST_ABEND: begin
            busy_q[i] <= 1'b0;
            st_q[i] <= ST_IDLE;
          end
          default: begin
            st_q[i] <= ST_IDLE;
          end
        endcase
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign mem_req = mem_busy_q;
  assign mem_we = mem_we_q;
  assign mem_addr = mem_addr_q;
  assign mem_wdata = mem_wdata_q;
  assign exec_start = start_q;
  assign exec_abort = abort_q;

  // Checks, watched on the slot each scenario drives, or across all slots
  default clocking cb_main @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_fault_acked;
    (st_q[0] == ST_FAULT) && scan_tick && nib(ctl_q, 0, `CSH_CT_ACK) && !soft_rst;
  endsequence

  sequence s_busy_released;
    (!xf_q[0] && !mf_q[0]) ##1 !busy_q[0];
  endsequence

  chk_fault_needs_busy: assert property ((xf_q & ~busy_q) == 4'h0)
    else $error("execution fault without busy");
  chk_cancel_needs_busy: assert property ((cb_q & ~busy_q) == 4'h0)
    else $error("cancel busy without busy");
  chk_mfault_with_xfault: assert property ((mf_q & ~xf_q) == 4'h0)
    else $error("memory fault without execution fault");
  chk_ack_releases: assert property (s_fault_acked |=> s_busy_released)
    else $error("acknowledge did not clear faults then busy");
  chk_start_raises_busy: assert property ((st_q[0] == ST_IDLE) && scan_tick && !soft_rst
      && nib(ctl_q, 0, `CSH_CT_REQ) && !nib(ctl_q, 0, `CSH_CT_CANCEL) |=> busy_q[0])
    else $error("request did not raise busy");
  chk_cancel_blocks_start: assert property (!busy_q[1] && nib(ctl_q, 1, `CSH_CT_CANCEL)
      && !reg_write |=> !busy_q[1])
    else $error("command started under held cancel");
  chk_signature_fault: assert property ((st_q[3] == ST_FETCH) && mem_done[3] && !soft_rst
      && mem_rdata[15:8] != `CSH_SIG |=> xf_q[3] && mf_q[3])
    else $error("bad signature not flagged");
  chk_coupled_hold: assert property ((st_q[0] == ST_HOLD) && nib(ctl_q, 0, `CSH_CT_REQ)
      && !soft_rst |=> busy_q[0])
    else $error("coupled busy dropped with request high");
  chk_uncoupled_done: assert property ((st_q[1] == ST_RUN) && !coupled_q[1] && exec_done[1]
      && !exec_err[1] && !nib(ctl_q, 1, `CSH_CT_CANCEL) && !soft_rst |=> !busy_q[1])
    else $error("uncoupled busy not dropped on completion");
  chk_full_reset: assert property (soft_rst |=> busy_q == 4'h0 && xf_q == 4'h0)
    else $error("full reset left a slot active");
endmodule

`default_nettype wire

/* shared/csh_pkg.sv */
// Types shared by the command slot block.
// Assumes csh_regs.svh holds all offsets and positions.
package csh_pkg;
  typedef logic [15:0] csh_word_t;
  typedef logic [2:0] csh_addr_t;
  typedef logic [1:0] csh_slot_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_FETCH, ST_RUN, ST_ERRWR, ST_FAULT, ST_RECOV, ST_HOLD, ST_ABORT, ST_ABEND
  } csh_state_e;
endpackage

/* shared/csh_regs.svh */
// Register offsets, field positions and fixed values of the command slot block.
// Assumes a 3-bit word address on the plain register port and 16-bit data.
`ifndef CSH_REGS_SVH
`define CSH_REGS_SVH

// Word addresses on the register port
`define CSH_ADDR_STATUS 3'h0
`define CSH_ADDR_CONTROL 3'h1
`define CSH_ADDR_MODCTL 3'h2
`define CSH_ADDR_PTR0 3'h3
`define CSH_ADDR_PTR3 3'h6

// Bit positions inside one slot nibble of slot_status_word
`define CSH_ST_XFAULT 0
`define CSH_ST_MFAULT 1
`define CSH_ST_BUSY 2
`define CSH_ST_CBUSY 3

// Bit positions inside one slot nibble of slot_control_word
`define CSH_CT_ACK 0
`define CSH_CT_SYNC 1
`define CSH_CT_REQ 2
`define CSH_CT_CANCEL 3

// Module reset bit in module_control_word
`define CSH_MOD_RST 0

// Slot count and nibble width
`define CSH_SLOTS 4
`define CSH_NIB 4

// Block layout in host memory and signature
`define CSH_OFS_ERRWORD 16'h0000
`define CSH_OFS_CONN 16'h0002
`define CSH_SIG 8'h4b
`define CSH_NULL_PTR 16'h0000

// Reset values
`define CSH_WORD_RST 16'h0000

`endif

/* testbench/csh_host_model.sv */
// Host memory and per-slot executor model facing the slot block.
// Assumes one clock; fault injection comes from bench inputs.
`timescale 1ns/1ps
`default_nettype none
module csh_host_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire csh_pkg::csh_word_t mem_addr,
  input wire csh_pkg::csh_word_t mem_wdata,
  output logic mem_ack,
  output logic mem_fail,
  output csh_pkg::csh_word_t mem_rdata,
  input wire logic [3:0] exec_start,
  input wire logic [3:0] exec_abort,
  output logic [3:0] exec_done,
  output logic [3:0] exec_err,
  output logic [63:0] exec_code,
  input wire logic bad_sig,
  input wire logic fail_wr,
  input wire logic [3:0] err_sel,
  input wire logic [3:0] hang,
  input wire csh_pkg::csh_word_t code,
  output csh_pkg::csh_word_t rd_addr,
  output csh_pkg::csh_word_t wr_addr,
  output csh_pkg::csh_word_t wr_data,
  output int wr_count
);
  import csh_pkg::*;
  logic [3:0] run_q;
  logic [3:0] cnt_q [4];
  assign exec_code = {4{code}};
  // Answer a cycle after the request; read data wander outside the answer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_ack <= 1'b0;
      mem_fail <= 1'b0;
      mem_rdata <= 16'h0000;
      wr_addr <= 16'h0000;
      rd_addr <= 16'h0000;
      wr_data <= 16'h0000;
      wr_count <= 0;
    end else begin
      mem_ack <= mem_req & ~mem_ack;
      mem_fail <= mem_req & ~mem_ack & mem_we & fail_wr;
      mem_rdata <= ~mem_rdata;
      if (mem_req & ~mem_ack & ~mem_we) begin
        mem_rdata <= {bad_sig ? 8'h00 : 8'h4b, mem_addr[7:0]};
        rd_addr <= mem_addr;
      end
      if (mem_req & ~mem_ack & mem_we) begin
        wr_addr <= mem_addr;
        wr_data <= mem_wdata;
        wr_count <= wr_count + 1;
      end
    end
  end
  // Hung slots finish only once the abort is raised
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      run_q <= 4'h0;
      exec_done <= 4'h0;
      exec_err <= 4'h0;
      cnt_q <= '{4'h0, 4'h0, 4'h0, 4'h0};
    end else begin
      for (int i = 0; i < 4; i++) begin
        exec_done[i] <= 1'b0;
        if (exec_start[i]) begin
          run_q[i] <= 1'b1;
          cnt_q[i] <= 4'h6;
        end else if (run_q[i] && (!hang[i] || exec_abort[i])) begin
          cnt_q[i] <= cnt_q[i] - 4'h1;
          if (cnt_q[i] == 4'h0) begin
            run_q[i] <= 1'b0;
            exec_done[i] <= 1'b1;
            exec_err[i] <= err_sel[i] & ~exec_abort[i];
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the four-slot command handshake block.
// Assumes the host model answers the memory and executor ports.
`timescale 1ns/1ps
`default_nettype none
`include "csh_regs.svh"
module tb_top;
  import csh_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  csh_addr_t reg_addr = 3'h0;
  csh_word_t reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic scan_end = 1'b0;
  csh_word_t reg_rdata, mem_addr, mem_wdata, mem_rdata, rd_addr, wr_addr, wr_data;
  csh_word_t code = 16'h0000;
  logic mem_req, mem_we, mem_ack, mem_fail;
  logic bad_sig = 1'b0;
  logic fail_wr = 1'b0;
  logic [3:0] err_sel = 4'h0;
  logic [3:0] hang = 4'h0;
  logic [3:0] exec_start, exec_abort, exec_done, exec_err;
  logic [63:0] exec_code;
  int wr_count, bad_count, comparisons, cyc;
  int nst [4] = '{0, 0, 0, 0};
  csh_word_t ptr [4];
  csh_word_t ctl = 16'h0000;
  csh_word_t v;
  csh_slots uut (.clock, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .scan_end, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
    .mem_fail, .mem_rdata, .exec_start, .exec_abort, .exec_done, .exec_err, .exec_code);
  csh_host_model host (.clock, .rst, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_ack, .mem_fail, .mem_rdata, .exec_start, .exec_abort, .exec_done,
    .exec_err, .exec_code, .bad_sig, .fail_wr, .err_sel, .hang, .code, .rd_addr, .wr_addr,
    .wr_data, .wr_count);
  always #50 clock = ~clock;
  task automatic results();
    if (bad_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end
  // Command starts per slot, to count repeats and refusals
  always @(posedge clock) begin
    for (int i = 0; i < 4; i++) begin
      if (exec_start[i] === 1'b1) begin
        nst[i]++;
      end
    end
  end
  task automatic chk(input string n, input csh_word_t e, input csh_word_t s);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input csh_addr_t a, input csh_word_t d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input csh_addr_t a, output csh_word_t d);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic setc(input int s, input logic [3:0] n);
    ctl[4*s +: 4] = n;
    wr(`CSH_ADDR_CONTROL, ctl);
  endtask
  // Pin held long enough to pass the two-stage synchroniser
  task automatic scan();
    @(posedge clock);
    scan_end <= 1'b1;
    repeat (4) @(posedge clock);
    scan_end <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  // Poll one slot nibble, bounded, checking flag invariants on every read
  task automatic wst(input int s, input logic [3:0] m, input logic [3:0] e);
    for (int k = 0; k < 60; k++) begin
      rd(`CSH_ADDR_STATUS, v);
      chk("flags", 16'h0000, ((v >> 3) | (v >> 1) | v) & ~(v >> 2) & 16'h1111);
      if ((v[4*s +: 4] & m) === e) break;
    end
    chk("slot", {12'h000, e}, {12'h000, v[4*s +: 4] & m});
  endtask
  // Slot nibble after an execution error: busy and fault, memory fault if the write failed
  function automatic logic [3:0] fault_nib(input logic mem_bad);
    fault_nib = 4'((1 << `CSH_ST_BUSY) | (1 << `CSH_ST_XFAULT) | (mem_bad << `CSH_ST_MFAULT));
  endfunction
  initial begin
    void'($urandom(88));
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), v);
      chk("reset", `CSH_WORD_RST, v);
    end
    for (int i = 0; i < 4; i++) begin
      ptr[i] = (i == 2) ? 16'h0000 : 16'($urandom_range(16'hfff0, 16'h0010));
      wr(3'(`CSH_ADDR_PTR0 + i), ptr[i]);
    end
    rd(`CSH_ADDR_PTR3, v);
    chk("ptr", ptr[3], v);
    wr(`CSH_ADDR_STATUS, 16'hffff);
    rd(`CSH_ADDR_STATUS, v);
    chk("status_ro", 16'h0000, v);
    // Coupled run with the request held past completion
    setc(0, 4'b0110);
    scan();
    wst(0, 4'h4, 4'h4);
    repeat (40) @(posedge clock);
    wst(0, 4'hf, 4'h4);
    setc(0, 4'b0000);
    wst(0, 4'h4, 4'h0);
    chk("starts", 16'h0001, 16'(nst[0]));
    chk("fetch_addr", ptr[0] + `CSH_OFS_CONN, rd_addr);
    // Uncoupled request held over three scans
    setc(1, 4'b0100);
    repeat (3) begin
      scan();
      repeat (30) @(posedge clock);
    end
    wst(1, 4'hf, 4'h0);
    chk("repeats", 16'h0003, 16'(nst[1]));
    setc(1, 4'b0000);
    scan();
    chk("repeats", 16'h0003, 16'(nst[1]));
    // Null pointer and bad signature side by side, then held acknowledge
    bad_sig <= 1'b1;
    ctl = 16'h6600;
    wr(`CSH_ADDR_CONTROL, ctl);
    scan();
    wst(2, 4'hf, 4'h7);
    wst(3, 4'hf, 4'h7);
    chk("writes", 16'h0000, 16'(wr_count));
    scan();
    wst(2, 4'hf, 4'h7);
    ctl = 16'h1100;
    wr(`CSH_ADDR_CONTROL, ctl);
    scan();
    wst(2, 4'hf, 4'h0);
    wst(3, 4'hf, 4'h0);
    bad_sig <= 1'b0;
    // Execution error, with and without a failing error word write
    err_sel <= 4'b0001;
    for (int f = 0; f < 2; f++) begin
      fail_wr <= f[0];
      code <= 16'($urandom());
      setc(0, 4'b0110);
      scan();
      wst(0, 4'hf, fault_nib(f[0]));
      chk("err_word", code, wr_data);
      chk("err_addr", ptr[0] + `CSH_OFS_ERRWORD, wr_addr);
      setc(0, 4'b0001);
      scan();
      wst(0, 4'hf, 4'h0);
    end
    err_sel <= 4'b0000;
    // Cancel a hung command, cancel left high afterwards
    hang <= 4'b0010;
    setc(1, 4'b0110);
    scan();
    wst(1, 4'h4, 4'h4);
    setc(1, 4'b1110);
    wst(1, 4'hc, 4'hc);
    wst(1, 4'hc, 4'h0);
    hang <= 4'b0000;
    scan();
    repeat (20) @(posedge clock);
    wst(1, 4'hf, 4'h0);
    chk("blocked", 16'h0004, 16'(nst[1]));
    setc(1, 4'b0000);
    // Full reset out of a faulted slot, which cancel alone cannot clear
    setc(2, 4'b0110);
    scan();
    wst(2, 4'hf, 4'h7);
    wr(`CSH_ADDR_CONTROL, 16'h8888);
    wr(`CSH_ADDR_MODCTL, 16'h0001);
    rd(`CSH_ADDR_STATUS, v);
    chk("full_reset", 16'h0000, v);
    rd(`CSH_ADDR_MODCTL, v);
    chk("modctl", 16'h0000, v);
    rd(`CSH_ADDR_CONTROL, v);
    chk("control", 16'h8888, v);
    results();
  end
endmodule
`default_nettype wire
